// [rtd_consts.svh]
// Constants for the reference and touch-detect timing control
// Contract
// [R1] Bit 4 high picks on-chip reference, low external; resets low.
// [R2] Reference power-up holds off conversions 0, 100, 500 or 1000 us.
// [R3] Settle-delay field resets to 00, no delay.
// [R4] Power-down bit high turns reference off between conversions; resets high.
// [R5] External reference selected keeps on-chip reference off always.
// [R6] On-chip, power-down low: always on; high: on only for conversions.
// [R7] Bit 0 picks 1.2 V when low (reset) or 2.5 V when high.
// [R8] Reference fields read back the last written value; reads change nothing.
// [R9] Precharge panel capacitance for time in bits 5:3 before sensing.
// [R10] Precharge codes give 20, 84, 276, 340, 1044, 1108, 1300, 1364 us.
// [R11] Sense wait from bits 2:0, 32 us up to 2.656 ms.
// [R12] On touch, drive panel, wait panel settle, then convert.
// [R13] Settle counter restarts on each reference off-to-on, gates conversions.
// [R14] Reserved bits ignore writes and read as zero.
`ifndef RTD_CONSTS_SVH
`define RTD_CONSTS_SVH

`define RTD_CLK_MHZ 100
`define RTD_CW 24
`define RTD_AW 8
`define RTD_DW 16
`define RTD_ADDR_REFC 8'h03
`define RTD_ADDR_TDC 8'h05
`define RTD_REFC_RST 16'h0002
`define RTD_TDC_RST 16'h0000
`define RTD_US2CYC(t) (24'((t) * `RTD_CLK_MHZ))
`define RTD_MS2CYC(t) (24'((t) * 1000 * `RTD_CLK_MHZ))

`define RTD_SETTLE0_US 0
`define RTD_SETTLE1_US 100
`define RTD_SETTLE2_US 500
`define RTD_SETTLE3_US 1000

`define RTD_PRE0_US 20
`define RTD_PRE1_US 84
`define RTD_PRE2_US 276
`define RTD_PRE3_US 340
`define RTD_PRE4_US 1044
`define RTD_PRE5_US 1108
`define RTD_PRE6_US 1300
`define RTD_PRE7_US 1364

`define RTD_SNS0_US 32
`define RTD_SNS1_US 96
`define RTD_SNS2_US 544
`define RTD_SNS3_US 608
`define RTD_SNS4_US 2080
`define RTD_SNS5_US 2144
`define RTD_SNS6_US 2592
`define RTD_SNS7_US 2656

`define RTD_PNL0_US 0
`define RTD_PNL1_US 100
`define RTD_PNL2_US 500
`define RTD_PNL3_MS 1
`define RTD_PNL4_MS 5
`define RTD_PNL5_MS 10
`define RTD_PNL6_MS 50
`define RTD_PNL7_MS 100

`endif

// [rtd_pkg.sv]
// Types for the reference and touch-detect timing control
`include "rtd_consts.svh"

package rtd_pkg;

	typedef logic [`RTD_CW-1:0] rtd_cnt_t;

	typedef enum logic [1:0] {
		RTD_R_IDLE,
		RTD_R_WAIT,
		RTD_R_CONV
	} rtd_ref_st_t;

	typedef enum logic [2:0] {
		RTD_T_IDLE,
		RTD_T_PRE,
		RTD_T_SENSE,
		RTD_T_PANEL,
		RTD_T_CONV
	} rtd_tch_st_t;

	typedef struct packed {
		logic [10:0] rsvd;
		logic int_sel;
		logic [1:0] settle;
		logic ref_auto_powerdown;
		logic volt_hi;
	} rtd_refc_t;

	typedef struct packed {
		logic [9:0] rsvd;
		logic [2:0] pre;
		logic [2:0] sense;
	} rtd_tdc_t;

	typedef struct packed {
		rtd_refc_t rc;
		rtd_tdc_t td;
		rtd_ref_st_t rst;
		rtd_tch_st_t tst;
		rtd_cnt_t rcnt;
		rtd_cnt_t tcnt;
		logic ref_on;
		logic conv_start;
		logic precharge;
		logic sensing;
		logic panel_drv;
		logic touch_miss;
		logic [`RTD_DW-1:0] rdata;
	} rtd_state_t;

endpackage

// [rtd_ref_touch_ctrl.sv]
// Reference power/settle and touch-detect precharge timing controller
`include "rtd_consts.svh"

module rtd_ref_touch_ctrl #(
	parameter logic [3:0][`RTD_CW-1:0] SETTLE_CYC = '{
		`RTD_US2CYC(`RTD_SETTLE3_US),
		`RTD_US2CYC(`RTD_SETTLE2_US),
		`RTD_US2CYC(`RTD_SETTLE1_US),
		`RTD_US2CYC(`RTD_SETTLE0_US)
	},
	parameter logic [7:0][`RTD_CW-1:0] PRE_CYC = '{
		`RTD_US2CYC(`RTD_PRE7_US),
		`RTD_US2CYC(`RTD_PRE6_US),
		`RTD_US2CYC(`RTD_PRE5_US),
		`RTD_US2CYC(`RTD_PRE4_US),
		`RTD_US2CYC(`RTD_PRE3_US),
		`RTD_US2CYC(`RTD_PRE2_US),
		`RTD_US2CYC(`RTD_PRE1_US),
		`RTD_US2CYC(`RTD_PRE0_US)
	},
	parameter logic [7:0][`RTD_CW-1:0] SENSE_CYC = '{
		`RTD_US2CYC(`RTD_SNS7_US),
		`RTD_US2CYC(`RTD_SNS6_US),
		`RTD_US2CYC(`RTD_SNS5_US),
		`RTD_US2CYC(`RTD_SNS4_US),
		`RTD_US2CYC(`RTD_SNS3_US),
		`RTD_US2CYC(`RTD_SNS2_US),
		`RTD_US2CYC(`RTD_SNS1_US),
		`RTD_US2CYC(`RTD_SNS0_US)
	},
	parameter logic [7:0][`RTD_CW-1:0] PANEL_CYC = '{
		`RTD_MS2CYC(`RTD_PNL7_MS),
		`RTD_MS2CYC(`RTD_PNL6_MS),
		`RTD_MS2CYC(`RTD_PNL5_MS),
		`RTD_MS2CYC(`RTD_PNL4_MS),
		`RTD_MS2CYC(`RTD_PNL3_MS),
		`RTD_US2CYC(`RTD_PNL2_US),
		`RTD_US2CYC(`RTD_PNL1_US),
		`RTD_US2CYC(`RTD_PNL0_US)
	}
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [`RTD_AW-1:0] REG_ADDR,
	input wire logic [`RTD_DW-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [`RTD_DW-1:0] REG_RDATA,
	// Converter handshake
	input wire logic CONV_REQ,
	input wire logic CONV_DONE,
	output logic CONV_START,
	// Reference controls
	output logic REF_INTERNAL,
	output logic REF_VOLT_HI,
	output logic REF_POWER_ON,
	// Touch detect
	input wire logic TOUCH_REQ,
	input wire logic TOUCH_DETECTED,
	input wire logic [2:0] PANEL_SETTLE_SEL,
	output logic PRECHARGE_ON,
	output logic SENSE_ON,
	output logic PANEL_DRIVE_ON,
	output logic TOUCH_MISS
);

	localparam rtd_pkg::rtd_state_t RST_ST = '{
		rc: `RTD_REFC_RST,
		td: `RTD_TDC_RST,
		rst: rtd_pkg::RTD_R_IDLE,
		tst: rtd_pkg::RTD_T_IDLE,
		default: '0
	};

	rtd_pkg::rtd_state_t s;
	rtd_pkg::rtd_state_t next_s;
	logic touch_go;
	logic conv_req;
	logic ref_want;
	// Write data seen as reference fields, for the checks only
	rtd_pkg::rtd_refc_t wr_refc;

	assign wr_refc = REG_WDATA;

	// Saturating countdown, also turns a length into a last index
	function automatic rtd_pkg::rtd_cnt_t minus1(
		input rtd_pkg::rtd_cnt_t v
	);
		minus1 = (v == '0) ? '0 : v - 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		touch_go = 1'b0;
		next_s.conv_start = 1'b0;
		next_s.touch_miss = 1'b0;
		next_s.rdata = '0;

		// [R14] Reserved bits dropped on write
		if (REG_WR && REG_ADDR == `RTD_ADDR_REFC) begin
			next_s.rc = REG_WDATA;
			next_s.rc.rsvd = '0;
		end
		if (REG_WR && REG_ADDR == `RTD_ADDR_TDC) begin
			next_s.td = REG_WDATA;
			next_s.td.rsvd = '0;
		end

		// [R8] Readback of stored fields, no side effect
		if (REG_RD) begin
			case (REG_ADDR)
				`RTD_ADDR_REFC: next_s.rdata = s.rc;
				`RTD_ADDR_TDC: next_s.rdata = s.td;
				default: next_s.rdata = '0;
			endcase
		end

		////////////////////////////////////////////////////////////////
		case (s.tst)
			rtd_pkg::RTD_T_IDLE: begin
				// [R9] Precharge starts the touch check
				if (TOUCH_REQ) begin
					next_s.tst = rtd_pkg::RTD_T_PRE;
					next_s.precharge = 1'b1;
					next_s.tcnt = minus1(PRE_CYC[s.td.pre]);
				end
			end
			rtd_pkg::RTD_T_PRE: begin
				// [R10] Precharge length from the code table
				if (s.tcnt == '0) begin
					next_s.tst = rtd_pkg::RTD_T_SENSE;
					next_s.precharge = 1'b0;
					next_s.sensing = 1'b1;
					next_s.tcnt = minus1(SENSE_CYC[s.td.sense]);
				end else begin
					next_s.tcnt = minus1(s.tcnt);
				end
			end
			rtd_pkg::RTD_T_SENSE: begin
				// [R12] Touch seen: driver on, panel settle
				if (TOUCH_DETECTED) begin
					next_s.tst = rtd_pkg::RTD_T_PANEL;
					next_s.sensing = 1'b0;
					next_s.panel_drv = 1'b1;
					next_s.tcnt = PANEL_CYC[PANEL_SETTLE_SEL];
				// [R11] Sense window ends without touch
				end else if (s.tcnt == '0) begin
					next_s.tst = rtd_pkg::RTD_T_IDLE;
					next_s.sensing = 1'b0;
					next_s.touch_miss = 1'b1;
				end else begin
					next_s.tcnt = minus1(s.tcnt);
				end
			end
			rtd_pkg::RTD_T_PANEL: begin
				// Conversion waits for an idle converter path
				if (s.tcnt != '0) begin
					next_s.tcnt = minus1(s.tcnt);
				end else if (s.rst == rtd_pkg::RTD_R_IDLE) begin
					touch_go = 1'b1;
					next_s.tst = rtd_pkg::RTD_T_CONV;
				end
			end
			rtd_pkg::RTD_T_CONV: begin
				if (CONV_DONE && s.rst == rtd_pkg::RTD_R_CONV) begin
					next_s.tst = rtd_pkg::RTD_T_IDLE;
					next_s.panel_drv = 1'b0;
				end
			end
			default: begin
				next_s.tst = rtd_pkg::RTD_T_IDLE;
				next_s.precharge = 1'b0;
				next_s.sensing = 1'b0;
				next_s.panel_drv = 1'b0;
			end
		endcase

		////////////////////////////////////////////////////////////////
		conv_req = CONV_REQ | touch_go;
		// [R5] [R6] [R4] Reference power decision
		ref_want = s.rc.int_sel & (~s.rc.ref_auto_powerdown
			| (s.rst != rtd_pkg::RTD_R_IDLE) | conv_req);
		next_s.ref_on = ref_want;

		// [R13] Settle count reloads on every power-up
		if (ref_want && !s.ref_on) begin
			next_s.rcnt = SETTLE_CYC[s.rc.settle];
		end else begin
			next_s.rcnt = minus1(s.rcnt);
		end

		case (s.rst)
			rtd_pkg::RTD_R_IDLE: begin
				if (conv_req) begin
					next_s.rst = rtd_pkg::RTD_R_WAIT;
				end
			end
			rtd_pkg::RTD_R_WAIT: begin
				// [R2] Conversion held until reference settled
				if (!s.rc.int_sel || (s.ref_on && s.rcnt == '0)) begin
					next_s.conv_start = 1'b1;
					next_s.rst = rtd_pkg::RTD_R_CONV;
				end
			end
			rtd_pkg::RTD_R_CONV: begin
				if (CONV_DONE) begin
					next_s.rst = rtd_pkg::RTD_R_IDLE;
				end
			end
			default: begin
				next_s.rst = rtd_pkg::RTD_R_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// [R3] [R1] [R7] Reset values of all fields
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			s <= RST_ST;
		end else begin
			s <= next_s;
		end
	end

	assign REG_RDATA = s.rdata;
	assign CONV_START = s.conv_start;
	assign REF_INTERNAL = s.rc.int_sel;
	assign REF_VOLT_HI = s.rc.volt_hi;
	assign REF_POWER_ON = s.ref_on;
	assign PRECHARGE_ON = s.precharge;
	assign SENSE_ON = s.sensing;
	assign PANEL_DRIVE_ON = s.panel_drv;
	assign TOUCH_MISS = s.touch_miss;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	a_reset_values: assert property ( // [R3]
		$past(!RST_N) |-> s.rc == `RTD_REFC_RST && s.td == `RTD_TDC_RST
	) else $error("Control fields not at reset values");

	a_ext_ref_off: assert property ( // [R5]
		!REF_INTERNAL |=> !REF_POWER_ON
	) else $error("On-chip reference on while external selected");

	a_ref_always_on: assert property ( // [R6]
		REF_INTERNAL && !s.rc.ref_auto_powerdown |=> REF_POWER_ON
	) else $error("Reference off with power-down clear");

	a_ref_off_idle: assert property ( // [R4]
		s.rc.ref_auto_powerdown && s.rst == rtd_pkg::RTD_R_IDLE && !conv_req
		|=> !REF_POWER_ON
	) else $error("Reference left on between conversions");

	a_settle_load: assert property ( // [R2]
		$rose(REF_POWER_ON) |-> s.rcnt == SETTLE_CYC[$past(s.rc.settle)]
	) else $error("Settle count not loaded at power-up");

	a_conv_gated: assert property ( // [R13]
		CONV_START && $past(REF_INTERNAL)
		|-> $past(s.rcnt) == '0 && $past(REF_POWER_ON)
	) else $error("Conversion started before reference settled");

	a_ref_readback: assert property ( // [R8]
		REG_RD && !REG_WR && REG_ADDR == `RTD_ADDR_REFC
		|=> REG_RDATA == $past(s.rc) && REG_RDATA[15:5] == '0
	) else $error("Reference register readback wrong");

	a_pre_load: assert property ( // [R10]
		$rose(PRECHARGE_ON) |-> s.tcnt == minus1(PRE_CYC[$past(s.td.pre)])
	) else $error("Precharge length not from code");

	a_pre_to_sense: assert property ( // [R9]
		PRECHARGE_ON && s.tcnt == '0 |=> !PRECHARGE_ON && SENSE_ON
	) else $error("Sensing did not follow precharge");

	a_sense_miss: assert property ( // [R11]
		SENSE_ON && s.tcnt == '0 && !TOUCH_DETECTED |=> TOUCH_MISS
	) else $error("Missed touch not reported at sense end");

	a_panel_first: assert property ( // [R12]
		SENSE_ON && TOUCH_DETECTED |=> PANEL_DRIVE_ON ##1 !CONV_START
	) else $error("Conversion not held for panel settle");

	a_int_mirror: assert property ( // [R1]
		REG_WR && REG_ADDR == `RTD_ADDR_REFC
		|=> REF_INTERNAL == $past(wr_refc.int_sel)
	) else $error("Reference source not taken from write");

	a_volt_mirror: assert property ( // [R7]
		REG_WR && REG_ADDR == `RTD_ADDR_REFC
		|=> REF_VOLT_HI == $past(wr_refc.volt_hi)
	) else $error("Reference level not taken from write");

	a_tdc_readback: assert property ( // [R14]
		REG_RD && !REG_WR && REG_ADDR == `RTD_ADDR_TDC
		|=> REG_RDATA == $past(s.td) && $past(s.td.rsvd) == '0
	) else $error("Timing register readback wrong");

	a_rdata_idle: assert property ( // [R8]
		!REG_RD |=> REG_RDATA == '0
	) else $error("Read data outside the read cycle");

	a_read_no_effect: assert property ( // [R8]
		REG_RD && !REG_WR
		|=> s.rc == $past(s.rc) && s.td == $past(s.td)
	) else $error("Read changed a control field");

	a_start_pulse: assert property ( // [R13]
		CONV_START |=> !CONV_START
	) else $error("Conversion start longer than one cycle");

	a_miss_pulse: assert property ( // [R11]
		TOUCH_MISS |=> !TOUCH_MISS
	) else $error("Missed-touch flag longer than one cycle");

	a_panel_hold: assert property ( // [R12]
		s.tst == rtd_pkg::RTD_T_PANEL && s.tcnt != '0
		|=> PANEL_DRIVE_ON && s.tst == rtd_pkg::RTD_T_PANEL
	) else $error("Panel settle cut short");

	a_pre_exclusive: assert property ( // [R9]
		!(PRECHARGE_ON && SENSE_ON)
	) else $error("Precharge and sensing at once");

	a_ref_off_after: assert property ( // [R6]
		s.rst == rtd_pkg::RTD_R_CONV && CONV_DONE
		##1 s.rc.ref_auto_powerdown && !conv_req |=> !REF_POWER_ON
	) else $error("Reference kept on after conversion");

	c_settled_conv: cover property (
		$rose(REF_POWER_ON) ##[1:300] CONV_START
	);
	c_touch_hit: cover property (
		SENSE_ON && TOUCH_DETECTED ##[1:300] CONV_START
	);
	c_touch_miss: cover property (TOUCH_MISS);
	c_ext_conv: cover property (
		!REF_INTERNAL && CONV_START
	);
	c_ref_kept_on: cover property (
		REF_INTERNAL && !s.rc.ref_auto_powerdown && CONV_START
	);

endmodule

// [rtd_ref_touch_ctrl_test.sv]
// Self-checking bench for the reference and touch-detect controller
module rtd_ref_touch_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// Short counts keep the run brief; expectations use the same tables
	localparam logic [3:0][23:0] ST = '{24'h1E, 24'h14, 24'h0A, 24'h00};
	localparam logic [7:0][23:0] PRE = '{24'h28, 24'h23, 24'h1E, 24'h19,
		24'h14, 24'h0F, 24'h0A, 24'h05};
	localparam logic [7:0][23:0] SNS = '{24'h13, 24'h12, 24'h11, 24'h10,
		24'h0F, 24'h0E, 24'h0D, 24'h0C};
	localparam logic [7:0][23:0] PNL = '{8{24'h06}};

	logic sys_clk, rst_n, reg_wr, reg_rd, conv_req, conv_done;
	logic touch_req, touch_det, conv_start, ref_int, ref_hi, ref_on;
	logic pre_on, sns_on, pnl_on, miss, r;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [2:0] pnl_sel;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int k, p, s;

	rtd_ref_touch_ctrl #(.SETTLE_CYC(ST), .PRE_CYC(PRE), .SENSE_CYC(SNS),
		.PANEL_CYC(PNL)) i_rtd_ref_touch_ctrl (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .CONV_REQ(conv_req), .CONV_DONE(conv_done),
		.CONV_START(conv_start), .REF_INTERNAL(ref_int),
		.REF_VOLT_HI(ref_hi), .REF_POWER_ON(ref_on),
		.TOUCH_REQ(touch_req), .TOUCH_DETECTED(touch_det),
		.PANEL_SETTLE_SEL(pnl_sel), .PRECHARGE_ON(pre_on),
		.SENSE_ON(sns_on), .PANEL_DRIVE_ON(pnl_on), .TOUCH_MISS(miss));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// A hang counts as a mismatch
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			$display("[FAIL] %0t timeout", $time);
			close_out();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkn(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			fail_count++;
			$display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask

	// k counts edges from the taking edge to the start pulse
	task automatic conv(output int n, output logic on);
		@(posedge sys_clk);
		conv_req <= 1'b1;
		@(posedge sys_clk);
		conv_req <= 1'b0;
		#1;
		on = ref_on;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (conv_start !== 1'b1 && n < 300);
	endtask

	task automatic done;
		@(posedge sys_clk);
		conv_done <= 1'b1;
		@(posedge sys_clk);
		conv_done <= 1'b0;
		#1;
	endtask

	task automatic touch(input logic det, output int pc, output int sc);
		@(posedge sys_clk);
		touch_req <= 1'b1;
		touch_det <= det;
		@(posedge sys_clk);
		touch_req <= 1'b0;
		#1;
		pc = 0;
		sc = 0;
		while (pre_on === 1'b1 && pc < 500) begin
			pc++;
			@(posedge sys_clk);
			#1;
		end
		while (sns_on === 1'b1 && sc < 500) begin
			sc++;
			@(posedge sys_clk);
			#1;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, reg_wr, reg_rd, conv_req, conv_done, touch_req} = 6'h00;
		touch_det = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		pnl_sel = 3'h7;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'h03, 16'h0002);
		rd(8'h05, 16'h0000);
		chk(16'({ref_int, ref_hi, ref_on}), 16'h0000);
		wr(8'h03, 16'hFFFF);
		rd(8'h03, 16'h001F);
		rd(8'h03, 16'h001F);
		chk(16'({ref_int, ref_hi}), 16'h0003);
		wr(8'h05, 16'hFFFF);
		rd(8'h05, 16'h003F);
		rd(8'h04, 16'h0000);
		// External reference, either power-down setting
		for (int i = 0; i < 2; i++) begin
			wr(8'h03, 16'(i << 1));
			conv(k, r);
			chk(16'(r), 16'h0000);
			chkn(k, 1);
			done();
		end
		// Each power-up restarts the settle count
		for (int c = 0; c < 4; c++) begin
			wr(8'h03, 16'h0012 | 16'(c << 2));
			conv(k, r);
			chk(16'(r), 16'h0001);
			chkn(k, 1 + int'(ST[c]));
			done();
			// Reference drops one cycle after the done edge
			@(posedge sys_clk);
			#1;
			chk(16'(ref_on), 16'h0000);
		end
		wr(8'h03, 16'h0015);
		repeat (int'(ST[1]) + 4) @(posedge sys_clk);
		#1;
		chk(16'({ref_on, ref_hi}), 16'h0003);
		conv(k, r);
		chkn(k, 1);
		done();
		chk(16'(ref_on), 16'h0001);
		wr(8'h03, 16'h0000);
		for (int c = 0; c < 8; c++) begin
			wr(8'h05, 16'((c << 3) | c));
			touch(1'b0, p, s);
			chkn(p, int'(PRE[c]));
			chkn(s, int'(SNS[c]));
			chk(16'(miss), 16'h0001);
		end
		touch(1'b1, p, s);
		chk(16'(pnl_on), 16'h0001);
		k = 0;
		while (conv_start !== 1'b1 && k < 100) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		chkn(k, int'(PNL[7]) + 2);
		done();
		chk(16'(pnl_on), 16'h0000);
		close_out();
	end
endmodule
